// file: tpps_map.svh
// register offsets, field positions and reset values of the timer pin select block
`ifndef TPPS_MAP_SVH
`define TPPS_MAP_SVH
`define TPPS_PORTC_SEL_OFFSET  8'h00
`define TPPS_PORTA_SEL_OFFSET  8'h04
`define TPPS_PIN_STATUS_OFFSET 8'h08
`define TPPS_PORTC_SEL_RESET   8'h00
`define TPPS_PORTA_SEL_RESET   8'h00
`define TPPS_PORTC_SEL_MASK    8'h07
`define TPPS_PORTA_SEL_MASK    8'h0f
`define TPPS_WIDTH_SEL_BIT     3
`define TPPS_TIMER_COUNT       3
`endif

// file: tpps_pkg.sv
// types shared by the timer pin select block
package tpps_pkg;
    typedef enum logic [1:0] {
        TPPS_IDLE = 2'b01,
        TPPS_ACK  = 2'b10
    } tpps_bus_state_type;
endpackage

// file: tpps_pin_route.sv
// one shared pin pair: timer output or port data onto a port c pin and a port a pin
`include "tpps_map.svh"
module tpps_pin_route (
    // selection
    input  wire logic cSelIo,
    input  wire logic aSelComp,
    // timer output
    input  wire logic timerOut,
    // port latches
    input  wire logic portCData,
    input  wire logic portAData,
    // routed pin levels
    output logic      portCPin,
    output logic      portAPin
);
    // port c: cleared bit gives the pin to the timer
    assign portCPin = cSelIo ? portCData : timerOut;
    // port a: set bit gives the pin the complementary output
    assign portAPin = aSelComp ? ~timerOut : portAData;
endmodule

// file: tpps_top.sv
// timer output pin multiplexer with its wishbone register file
// Behaviour
// - port a and c pins may carry the three timers' signals as alternate function.
// - output alternate function chosen only by the two pin select registers.
// - timer input routing belongs to each timer, not to these registers.
// - port c bit 0 clear routes timer zero output; set gives io; reset zero.
// - port c bit 1 clear routes timer one output; set gives io.
// - port c bit 2 clear routes timer two output; set gives io; bits 3-7 unused.
//
// The implementer's own choices: the address map and the Wishbone interface to the registers.
`include "tpps_map.svh"
module tpps_top (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    // timer outputs
    input  wire logic        timer_zero_output,
    input  wire logic        timer_one_output,
    input  wire logic        timer_two_output,
    // port data latches for the shared pins
    input  wire logic [2:0]  portCData,
    input  wire logic [2:0]  portAData,
    // routed pin levels
    output logic             port_c_shared_pin_one,
    output logic             port_c_shared_pin_two,
    output logic             port_c_shared_pin_three,
    output logic             port_a_shared_pin_one,
    output logic             port_a_shared_pin_two,
    output logic             port_a_shared_pin_three,
    output logic             port_a_width_select
);
    // bus handshake state and its next value
    tpps_pkg::tpps_bus_state_type busState_q;
    tpps_pkg::tpps_bus_state_type busState_d;
    // selection registers and their next values
    logic [7:0]  portCSel_q;
    logic [7:0]  portCSel_d;
    logic [7:0]  portASel_q;
    logic [7:0]  portASel_d;
    // answer and read data next values
    logic        wbAck_d;
    logic        wbErr_d;
    logic [31:0] rdData_d;
    // routing nets
    logic [2:0]  timerOut;
    logic [2:0]  cPinComb;
    logic [2:0]  aPinComb;
    // decoded request
    logic        request;
    logic        hit;
    logic        selCHit;
    logic        selAHit;
    logic        statusHit;
    logic        wrLane0;

    ////////////////////////////////////////////////////////////////////////
    // bus decode; a request is only taken while idle, so the cycle after an answer is ignored
    assign request   = wb_cyc_i & wb_stb_i & (busState_q == tpps_pkg::TPPS_IDLE);
    assign selCHit   = (wb_adr_i == `TPPS_PORTC_SEL_OFFSET);
    assign selAHit   = (wb_adr_i == `TPPS_PORTA_SEL_OFFSET);
    assign statusHit = (wb_adr_i == `TPPS_PIN_STATUS_OFFSET);
    assign hit       = selCHit | selAHit | statusHit;
    // a write without lane 0 is still answered, it just stores nothing
    assign wrLane0   = request & wb_we_i & wb_sel_i[0];

    // next state: one-cycle answer, then a dead cycle so ack drops before the next request
    always_comb begin
        busState_d = busState_q;
        case (busState_q)
            tpps_pkg::TPPS_IDLE: begin
                if (request) begin
                    busState_d = tpps_pkg::TPPS_ACK;
                end
            end
            tpps_pkg::TPPS_ACK: begin
                busState_d = tpps_pkg::TPPS_IDLE;
            end
            default: begin
                // an illegal code falls back to idle rather than locking the bus
                busState_d = tpps_pkg::TPPS_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            busState_q <= tpps_pkg::TPPS_IDLE;
        end else begin
            busState_q <= busState_d;
        end
    end

    // answer next values: a mapped address is acknowledged, anything else refused;
    // both last one cycle because the state machine refuses a request while one stands
    assign wbAck_d = request & hit;
    assign wbErr_d = request & ~hit;

    // answer registers
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
        end else begin
            wb_ack_o <= wbAck_d;
            wb_err_o <= wbErr_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // selection registers: sole owners of output routing
    // port c next value: unused bits are masked so they always read back zero
    always_comb begin
        portCSel_d = portCSel_q;
        if (wrLane0 && selCHit) begin
            portCSel_d = wb_dat_i[7:0] & `TPPS_PORTC_SEL_MASK;
        end
    end

    // port a next value: bits 3:0 only, the width bit included
    always_comb begin
        portASel_d = portASel_q;
        if (wrLane0 && selAHit) begin
            portASel_d = wb_dat_i[7:0] & `TPPS_PORTA_SEL_MASK;
        end
    end

    // port c select register
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            portCSel_q <= `TPPS_PORTC_SEL_RESET;
        end else begin
            portCSel_q <= portCSel_d;
        end
    end

    // port a select register
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            portASel_q <= `TPPS_PORTA_SEL_RESET;
        end else begin
            portASel_q <= portASel_d;
        end
    end

    // read data next value; unused bits read zero
    // the status view is taken before the pin flops and registered on the same edge, so it matches the pins
    always_comb begin
        rdData_d = wb_dat_o;
        if (request && !wb_we_i) begin
            // status word: port c levels in bits 2:0, port a levels in bits 5:3
            case (wb_adr_i)
                `TPPS_PORTC_SEL_OFFSET:  rdData_d = {24'h00_0000, portCSel_q};
                `TPPS_PORTA_SEL_OFFSET:  rdData_d = {24'h00_0000, portASel_q};
                `TPPS_PIN_STATUS_OFFSET: rdData_d = {26'h000_0000, aPinComb, cPinComb};
                default:                 rdData_d = 32'h0000_0000;
            endcase
        end
    end

    // read data register, holds until the next read is answered
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_dat_o <= rdData_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-timer routing of the outputs only
    // timer input routing is not here: each timer picks its own input pins
    assign timerOut = {timer_two_output, timer_one_output, timer_zero_output};

    for (genvar i = 0; i < `TPPS_TIMER_COUNT; i++) begin : gRoute
        tpps_pin_route uRoute (
            .cSelIo    (portCSel_q[i]),
            .aSelComp  (portASel_q[i]),
            .timerOut  (timerOut[i]),
            .portCData (portCData[i]),
            .portAData (portAData[i]),
            .portCPin  (cPinComb[i]),
            .portAPin  (aPinComb[i])
        );
    end

    // registered pins, one cycle behind the sources; every output leaves a flop,
    // traded for a cycle of lag between a timer edge and its pin
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            // port c pins
            port_c_shared_pin_one   <= 1'b0;
            port_c_shared_pin_two   <= 1'b0;
            port_c_shared_pin_three <= 1'b0;
            // port a pins and width
            port_a_shared_pin_one   <= 1'b0;
            port_a_shared_pin_two   <= 1'b0;
            port_a_shared_pin_three <= 1'b0;
            port_a_width_select     <= 1'b0;
        end else begin
            // port c pins
            port_c_shared_pin_one   <= cPinComb[0];
            port_c_shared_pin_two   <= cPinComb[1];
            port_c_shared_pin_three <= cPinComb[2];
            // port a pins
            port_a_shared_pin_one   <= aPinComb[0];
            port_a_shared_pin_two   <= aPinComb[1];
            port_a_shared_pin_three <= aPinComb[2];
            // port a width: 1 gives eight bits, 0 gives seven
            port_a_width_select     <= portASel_q[`TPPS_WIDTH_SEL_BIT];
        end
    end
endmodule

// file: tpps_timer_model.sv
// free-running model of the three timer units feeding the pin multiplexer
module tpps_timer_model (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    // true outputs of timers zero to two
    output logic      [2:0] tmrOut
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_q;
    // plain timer mode only, so the shared port c pins may be handed back as io
    always_ff @(posedge sys_clk) begin
        cnt_q <= resetn ? cnt_q + 4'h1 : 4'h0;
    end
    // three rates: fast, medium, slow toggling units
    assign tmrOut = {cnt_q[3], cnt_q[1], cnt_q[0]};
endmodule

// file: tpps_top_asserts.sv
// port-level assertions of the timer pin select block
`include "tpps_map.svh"
module tpps_top_asserts (
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        resetn,
    // wishbone
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        wb_err_o,
    // timers and port latches
    input wire logic        timer_zero_output,
    input wire logic        timer_one_output,
    input wire logic        timer_two_output,
    input wire logic [2:0]  portCData,
    input wire logic [2:0]  portAData,
    // routed pins
    input wire logic        port_c_shared_pin_one,
    input wire logic        port_c_shared_pin_two,
    input wire logic        port_c_shared_pin_three,
    input wire logic        port_a_shared_pin_one,
    input wire logic        port_a_shared_pin_two,
    input wire logic        port_a_shared_pin_three,
    input wire logic        port_a_width_select
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] cSel_q;
    logic [3:0] aSel_q;
    // a request is taken only while no answer stands
    wire logic       take  = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    wire logic       store = take & wb_we_i & wb_sel_i[0];
    wire logic [2:0] tmr   = {timer_two_output, timer_one_output, timer_zero_output};
    // shadow selects, updated on the accepting edge like the real registers
    always_ff @(posedge sys_clk) begin
        cSel_q <= !resetn ? 3'h0 : (store && wb_adr_i == `TPPS_PORTC_SEL_OFFSET) ? wb_dat_i[2:0] : cSel_q;
    end
    always_ff @(posedge sys_clk) begin
        aSel_q <= !resetn ? 4'h0 : (store && wb_adr_i == `TPPS_PORTA_SEL_OFFSET) ? wb_dat_i[3:0] : aSel_q;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // pins lag by one clock; $past(resetn) skips the edge right after release
    c_pin_one_a: assert property ($past(resetn) |-> port_c_shared_pin_one == $past(cSel_q[0] ? portCData[0] : tmr[0]))
        else $error("port c pin one misrouted");
    c_pin_two_a: assert property ($past(resetn) |-> port_c_shared_pin_two == $past(cSel_q[1] ? portCData[1] : tmr[1]))
        else $error("port c pin two misrouted");
    c_pin_three_a: assert property ($past(resetn) |-> port_c_shared_pin_three == $past(cSel_q[2] ? portCData[2] : tmr[2]))
        else $error("port c pin three misrouted");
    a_pins_a: assert property ($past(resetn) |-> {port_a_shared_pin_three, port_a_shared_pin_two,
        port_a_shared_pin_one} == $past(aSel_q[2:0] & ~tmr | ~aSel_q[2:0] & portAData)) else $error("port a pins misrouted");
    width_sel_a: assert property ($past(resetn) |-> port_a_width_select == $past(aSel_q[3]))
        else $error("port a width wrong");
    bus_answer_a: assert property (take |=> wb_ack_o ^ wb_err_o)
        else $error("request not answered once");
    unmapped_err_a: assert property (take && !(wb_adr_i inside {`TPPS_PORTC_SEL_OFFSET, `TPPS_PORTA_SEL_OFFSET,
        `TPPS_PIN_STATUS_OFFSET}) |=> wb_err_o)
        else $error("unmapped address not refused");
    c_readback_a: assert property (take && !wb_we_i && wb_adr_i == `TPPS_PORTC_SEL_OFFSET |=> wb_dat_o == {29'h0, cSel_q})
        else $error("port c select read wrong");
    a_readback_a: assert property (take && !wb_we_i && wb_adr_i == `TPPS_PORTA_SEL_OFFSET |=> wb_dat_o == {28'h0, aSel_q})
        else $error("port a select read wrong");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
endmodule
bind tpps_top tpps_top_asserts chk (.*);

// file: tpps_top_tb.sv
// self-checking bench of the timer pin select block
module tpps_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk = 0, resetn = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o, wb_err_o, width, erb;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, rd;
    logic [3:0]  wb_sel_i = 4'h0, aSel = 4'h0;
    logic [2:0]  tmr, portCData = 3'h0, portAData = 3'h0, cPin, aPin, cSel = 3'h0, prevT;
    int          error_cnt = 0, check_count = 0;
    // rows: address, write value, expected read
    logic [23:0] rows [4] = '{24'h00_ff07, 24'h04_ff0f, 24'h04_0a0a, 24'h00_0505};
    tpps_timer_model tmrs (.sys_clk, .resetn, .tmrOut(tmr));
    tpps_top dut (.sys_clk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i,
        .wb_dat_o, .wb_ack_o, .wb_err_o, .timer_zero_output(tmr[0]), .timer_one_output(tmr[1]),
        .timer_two_output(tmr[2]), .portCData, .portAData, .port_c_shared_pin_one(cPin[0]),
        .port_c_shared_pin_two(cPin[1]), .port_c_shared_pin_three(cPin[2]), .port_a_shared_pin_one(aPin[0]),
        .port_a_shared_pin_two(aPin[1]), .port_a_shared_pin_three(aPin[2]), .port_a_width_select(width));
    initial forever #12.5 sys_clk = ~sys_clk;
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            error_cnt++;
        end
    endtask
    // one classic cycle; waits for ack or err, only the watchdog ends a hang
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, we, adr, dat, sel};
        do begin
            @(posedge sys_clk);
        end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
        rd = wb_dat_o;
        erb = wb_err_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        @(posedge sys_clk);
    endtask
    // pins show the sources seen one edge earlier
    task automatic pins;
        logic [2:0] pc, pa;
        @(posedge sys_clk);
        prevT = tmr;
        pc = portCData;
        pa = portAData;
        @(negedge sys_clk);
        cmp(32'({width, aPin, cPin}), 32'({aSel[3], aSel[2:0] & ~prevT | ~aSel[2:0] & pa, cSel & pc | ~cSel & prevT}));
        @(posedge sys_clk);
    endtask
    task automatic conclude;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge sys_clk);
        resetn <= 1;
        foreach (rows[i]) begin
            portCData <= 3'(i + 3);
            portAData <= 3'(5 - i);
            wb(1, rows[i][23:16], {24'h0, rows[i][15:8]}, 4'hf);
            wb(0, rows[i][23:16], 32'h0, 4'hf);
            cmp(rd, {24'h0, rows[i][7:0]});
            if (rows[i][23:16] == 8'h00) cSel = rows[i][2:0];
            else aSel = rows[i][3:0];
            pins();
        end
        // lane 0 off stores nothing, unmapped address is refused
        wb(1, 8'h00, 32'h0000_0002, 4'he);
        wb(0, 8'h00, 32'h0, 4'hf);
        cmp(rd, 32'h0000_0005);
        wb(0, 8'h0c, 32'h0, 4'hf);
        cmp(32'(erb), 32'h0000_0001);
        // every pin handed to io: the status word is just the port latches
        wb(1, 8'h00, 32'h0000_0007, 4'h1);
        wb(1, 8'h04, 32'h0000_0000, 4'h1);
        wb(0, 8'h08, 32'h0, 4'hf);
        cmp(rd, {26'h000_0000, portAData, portCData});
        cSel = 3'h7;
        aSel = 4'h0;
        pins();
        // mid-run reset clears both selects
        resetn <= 0;
        repeat (2) @(posedge sys_clk);
        resetn <= 1;
        cSel = 3'h0;
        aSel = 4'h0;
        wb(0, 8'h04, 32'h0, 4'hf);
        cmp(rd, 32'h0);
        wb(0, 8'h00, 32'h0, 4'hf);
        cmp(rd, 32'h0);
        pins();
        conclude();
    end
    // watchdog well beyond the seventy or so cycles the run needs
    initial begin
        repeat (2000) @(posedge sys_clk);
        error_cnt++;
        conclude();
    end
endmodule
